// File: rtl/cse_pkg.sv
package cse_pkg;

    localparam int NUM_CTR = 4;
    localparam int CTR_W   = 44;
    localparam int HI_W    = CTR_W - 32;
    localparam int INC_W   = 5;
    localparam int NODE_W  = 3;
    localparam int ADR_W   = 8;

    // event codes
    localparam logic [7:0] EV_TICK    = 8'h00;
    localparam logic [7:0] EV_REFILT  = 8'h1F;
    localparam logic [7:0] EV_FQ_MISS = 8'h21;
    localparam logic [7:0] EV_LOOKUP  = 8'h34;
    localparam logic [7:0] EV_EVICT   = 8'h37;
    localparam logic [7:0] EV_MISC    = 8'h39;

    // counters each event may use, bit n for counter n
    localparam logic [3:0] OK_TICK    = 4'hF;
    localparam logic [3:0] OK_REFILT  = 4'hE;
    localparam logic [3:0] OK_PAIR    = 4'h3;

    localparam logic [INC_W-1:0] MAX_INC = 5'h14;
    localparam logic [INC_W-1:0] ONE_INC = 5'h01;
    localparam logic [4:0]       TID_UNASSOC = 5'h0F;

    // unit-mask bit positions
    localparam int UM_BASE  = 0;
    localparam int UM_READ  = 1;
    localparam int UM_WRITE = 2;
    localparam int UM_SNOOP = 3;
    localparam int UM_NID   = 6;

    // register group in address bits 7:4, index in bits 3:2; filter at byte 0x30
    localparam logic [3:0] GRP_CTL    = 4'h0;
    localparam logic [3:0] GRP_CTR_LO = 4'h1;
    localparam logic [3:0] GRP_CTR_HI = 4'h2;
    localparam logic [3:0] GRP_FILT   = 4'h3;
    localparam logic [7:0] REG_FILTER = 8'h30;

    typedef enum logic [1:0] {
        CSE_REQ_READ,
        CSE_REQ_WRITE,
        CSE_REQ_SNOOP,
        CSE_REQ_OTHER
    } cse_req_t;

    typedef struct packed {
        logic [7:0] thresh;
        logic       invert;
        logic       en;
        logic [1:0] rsv_hi;
        logic       tid_en;
        logic       edge_det;
        logic [1:0] rsv_lo;
        logic [7:0] umask;
        logic [7:0] ev;
    } cse_ctl_t;

    typedef struct packed {
        logic [8:0] opc;
        logic [4:0] state;
        logic [7:0] nid;
        logic [4:0] rsv;
        logic [4:0] tid;
    } cse_filt_t;

    // one clock of event sources from the slice pipeline
    typedef struct packed {
        logic              lk_valid;
        cse_req_t          lk_kind;
        logic [4:0]        lk_state;
        logic [NODE_W-1:0] lk_node;
        logic [4:0]        lk_tid;
        logic              ev_valid;
        logic [3:0]        ev_state;
        logic [NODE_W-1:0] ev_node;
        logic [INC_W-1:0]  fq_miss_occ;
        logic [3:0]        misc;
        logic [4:0]        misc_tid;
    } cse_events_t;

endpackage : cse_pkg

// File: rtl/cse_inc_shaper.sv
`timescale 1ns/1ps
module cse_inc_shaper #(
    parameter int W = 5
) (
    input  wire logic         sys_clk,  // uncore clock
    input  wire logic         rst_n,    // async reset
    input  wire logic [W-1:0] raw,      // unshaped increment
    input  wire logic [7:0]   thresh,   // zero passes raw
    input  wire logic         invert,   // compare below instead
    input  wire logic         edge_det, // count rising edges only
    output logic      [W-1:0] inc       // shaped increment
);
    logic prev;
    logic next_prev;
    logic cond;

    // threshold turns a count into a 0/1 per clock
    always_comb begin
        cond = ({{(8-W){1'b0}}, raw} >= thresh) ^ invert;
        next_prev = cond;
        if (thresh == 8'h00) begin
            inc = raw;
        end else if (edge_det) begin
            inc = {{(W-1){1'b0}}, cond & ~prev};
        end else begin
            inc = {{(W-1){1'b0}}, cond};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end
endmodule : cse_inc_shaper

// File: rtl/cse_slice_event_select.sv
`timescale 1ns/1ps
module cse_slice_event_select (
    input  wire logic                      sys_clk,  // uncore clock
    input  wire logic                      rst_n,    // async reset
    input  wire logic                      wb_cyc_i, // bus cycle
    input  wire logic                      wb_stb_i, // strobe
    input  wire logic                      wb_we_i,  // write
    input  wire logic [cse_pkg::ADR_W-1:0] wb_adr_i, // byte address
    input  wire logic [3:0]                wb_sel_i, // byte lanes
    input  wire logic [31:0]               wb_dat_i, // write data
    output logic      [31:0]               wb_dat_o, // read data
    output logic                           wb_ack_o, // acknowledge
    input  wire cse_pkg::cse_events_t      events    // pipeline events
);
    localparam int N = cse_pkg::NUM_CTR;
    localparam int IW = cse_pkg::INC_W;
    localparam int CW = cse_pkg::CTR_W;

    cse_pkg::cse_ctl_t  ctl      [N];
    cse_pkg::cse_ctl_t  next_ctl [N];
    cse_pkg::cse_filt_t filt;
    cse_pkg::cse_filt_t next_filt;
    logic [CW-1:0]      ctr      [N];
    logic [CW-1:0]      next_ctr [N];
    logic [IW-1:0]      raw      [N];
    logic [IW-1:0]      inc      [N];
    logic [31:0]        next_dat;
    logic               next_ack;

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // counters an event code may use
    function automatic logic [3:0] allowed(input logic [7:0] ev);
        logic [3:0] m;
        m = 4'h0;
        case (ev)
            cse_pkg::EV_TICK:    m = cse_pkg::OK_TICK;
            cse_pkg::EV_REFILT:  m = cse_pkg::OK_REFILT;
            cse_pkg::EV_FQ_MISS: m = cse_pkg::OK_PAIR;
            cse_pkg::EV_LOOKUP:  m = cse_pkg::OK_PAIR;
            cse_pkg::EV_EVICT:   m = cse_pkg::OK_PAIR;
            cse_pkg::EV_MISC:    m = cse_pkg::OK_PAIR;
            default:             m = 4'h0;
        endcase
        return m;
    endfunction : allowed

    // raw occurrences this clock for one counter's programming
    function automatic logic [IW-1:0] raw_count(
        input cse_pkg::cse_ctl_t    c,
        input cse_pkg::cse_filt_t   f,
        input cse_pkg::cse_events_t e,
        input logic [IW-1:0]        occ0,
        input logic [1:0]           idx);
        logic [IW-1:0] n;
        logic [7:0]    um;
        logic [3:0]    okm;
        logic          kind_ok;
        logic          nid_ok;
        logic          tid_ok;
        logic          st_ok;
        n = '0;
        um = c.umask;
        okm = allowed(c.ev);
        kind_ok = 1'b0;
        nid_ok = 1'b0;
        tid_ok = 1'b0;
        st_ok = 1'b0;
        case (c.ev)
            cse_pkg::EV_TICK: begin
                n = cse_pkg::ONE_INC;
            end
            cse_pkg::EV_REFILT: begin
                n = occ0;
            end
            cse_pkg::EV_FQ_MISS: begin
                n = e.fq_miss_occ;
            end
            cse_pkg::EV_LOOKUP: begin
                // bits 1..3 pick request kinds; none set means any
                kind_ok = (um[cse_pkg::UM_SNOOP:cse_pkg::UM_READ] == 3'h0)
                    || (um[cse_pkg::UM_READ]
                        && e.lk_kind == cse_pkg::CSE_REQ_READ)
                    || (um[cse_pkg::UM_WRITE]
                        && e.lk_kind == cse_pkg::CSE_REQ_WRITE)
                    || (um[cse_pkg::UM_SNOOP]
                        && e.lk_kind == cse_pkg::CSE_REQ_SNOOP);
                nid_ok = !um[cse_pkg::UM_NID]
                    || f.nid[e.lk_node];
                st_ok = |(f.state & e.lk_state);
                tid_ok = !c.tid_en || (e.lk_tid == f.tid);
                n = {{(IW-1){1'b0}}, e.lk_valid
                    && um[cse_pkg::UM_BASE] && st_ok
                    && kind_ok && nid_ok && tid_ok};
            end
            cse_pkg::EV_EVICT: begin
                st_ok = |(um[3:0] & e.ev_state)
                    || (um[3:0] == 4'h0 && um[cse_pkg::UM_NID]);
                nid_ok = !um[cse_pkg::UM_NID]
                    || f.nid[e.ev_node];
                // evictions carry no thread of their own
                tid_ok = !c.tid_en
                    || (f.tid == cse_pkg::TID_UNASSOC);
                n = {{(IW-1){1'b0}},
                    e.ev_valid && st_ok && nid_ok && tid_ok};
            end
            cse_pkg::EV_MISC: begin
                // bit 0 silent, 1 alias, 2 undescribed, 3 rfo-S
                tid_ok = !c.tid_en || (e.misc_tid == f.tid);
                n = {{(IW-1){1'b0}},
                    |(um[3:0] & e.misc) && tid_ok};
            end
            default: begin
                n = '0;
            end
        endcase
        if (!okm[idx]) begin
            n = '0;
        end
        if (n > cse_pkg::MAX_INC) begin
            n = cse_pkg::MAX_INC;
        end
        if (!c.en) begin
            n = '0;
        end
        return n;
    endfunction : raw_count

    // per-counter event match and shaping
    for (genvar g = 0; g < N; g++) begin : g_ctr
        always_comb begin
            raw[g] = raw_count(ctl[g], filt, events,
                (g == 0) ? '0 : raw[0],
                2'(g));
        end

        cse_inc_shaper #(
            .W (IW)
        ) u_shape (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .raw      (raw[g]),
            .thresh   (ctl[g].thresh),
            .invert   (ctl[g].invert),
            .edge_det (ctl[g].edge_det),
            .inc      (inc[g])
        );
    end

    // bus decode, register writes and counter accumulation
    always_comb begin
        logic       take;
        logic [3:0] grp;
        logic [1:0] idx;
        logic       mapped;
        take = wb_cyc_i && wb_stb_i && !wb_ack_o;
        grp = wb_adr_i[7:4];
        idx = wb_adr_i[3:2];
        mapped = (wb_adr_i[1:0] == 2'h0)
            && (grp != cse_pkg::GRP_FILT
                || wb_adr_i == cse_pkg::REG_FILTER);
        next_filt = filt;
        next_ack = take; // one-cycle ack pulse
        next_dat = wb_dat_o;
        for (int i = 0; i < N; i++) begin
            next_ctl[i] = ctl[i];
            next_ctr[i] = ctr[i] + {{(CW-IW){1'b0}}, inc[i]};
        end
        if (take) begin
            next_dat = 32'h0000_0000;
            // unmapped addresses still ack, read zero, ignore writes
            if (mapped) begin
                case (grp)
                    cse_pkg::GRP_CTL: begin
                        next_dat = ctl[idx];
                        if (wb_we_i) begin
                            next_ctl[idx] = merge(ctl[idx], wb_dat_i,
                                wb_sel_i);
                        end
                    end
                    cse_pkg::GRP_CTR_LO: begin
                        next_dat = ctr[idx][31:0];
                        if (wb_we_i) begin
                            // software write wins over counting
                            next_ctr[idx][31:0] = merge(ctr[idx][31:0],
                                wb_dat_i, wb_sel_i);
                            next_ctr[idx][CW-1:32] = ctr[idx][CW-1:32];
                        end
                    end
                    cse_pkg::GRP_CTR_HI: begin
                        next_dat = {{(64-CW){1'b0}},
                            ctr[idx][CW-1:32]};
                        if (wb_we_i) begin
                            next_ctr[idx][CW-1:32] = cse_pkg::HI_W'(
                                merge({{(64-CW){1'b0}},
                                ctr[idx][CW-1:32]},
                                wb_dat_i, wb_sel_i));
                            next_ctr[idx][31:0] = ctr[idx][31:0];
                        end
                    end
                    cse_pkg::GRP_FILT: begin
                        next_dat = filt;
                        if (wb_we_i) begin
                            next_filt = merge(filt, wb_dat_i,
                                wb_sel_i);
                            next_filt.rsv = '0;
                        end
                    end
                    default: begin
                        next_dat = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // register state; everything clears at reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt <= '0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            for (int i = 0; i < N; i++) begin
                ctl[i] <= '0;
                ctr[i] <= '0;
            end
        end else begin
            filt <= next_filt;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            for (int i = 0; i < N; i++) begin
                ctl[i] <= next_ctl[i];
                ctr[i] <= next_ctr[i];
            end
        end
    end
endmodule : cse_slice_event_select

// File: sim/cse_bus_monitor.sv
`timescale 1ns/1ps
module cse_bus_monitor (
    input wire logic                      sys_clk,  // clock
    input wire logic                      rst_n,    // reset
    input wire logic                      wb_cyc_i, // cycle
    input wire logic                      wb_stb_i, // strobe
    input wire logic                      wb_we_i,  // write
    input wire logic [cse_pkg::ADR_W-1:0] wb_adr_i, // address
    input wire logic [31:0]               wb_dat_o, // read data
    input wire logic                      wb_ack_o  // acknowledge
);
    logic rd_ack;
    logic req;
    // read answers only; a write also loads read data, with the register's old value or zero
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    a_ack_next: assert property (req |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("acknowledge without request");
    a_hi_zero: assert property (
        rd_ack && wb_adr_i[7:4] == 4'h2 |-> wb_dat_o[31:12] == 20'h0)
        else $error("counter upper bits not zero");
    a_filt_rsv: assert property (
        rd_ack && wb_adr_i == 8'h30 |-> wb_dat_o[9:5] == 5'h0)
        else $error("filter reserved bits not zero");
    a_unmapped_zero: assert property (
        rd_ack && wb_adr_i > 8'h30 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_misalign_zero: assert property (
        rd_ack && wb_adr_i[1:0] != 2'b00 |-> wb_dat_o == 32'h0)
        else $error("misaligned read not zero");
    a_data_hold: assert property (!req |=> $stable(wb_dat_o))
        else $error("read data moved without request");
endmodule : cse_bus_monitor

bind cse_slice_event_select cse_bus_monitor u_mon (.sys_clk, .rst_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o);

// File: sim/cse_event_source.sv
`timescale 1ns/1ps
module cse_event_source (
    input  wire logic            sys_clk, // clock
    input  wire logic            rst_n,   // reset
    input  wire logic            go,      // start sweep
    output logic                 busy,    // sweeping
    output cse_pkg::cse_events_t events   // to slice
);
    logic [4:0] idx;
    logic [4:0] left;
    logic [4:0] next_idx;
    logic [4:0] next_left;
    // idx free-runs mod 20 so idle fields never sit still
    always_comb begin
        next_idx = (idx == 5'h13) ? 5'h00 : idx + 5'h01;
        next_left = (left != 5'h00) ? left - 5'h01 : (go ? 5'h14 : 5'h00);
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= 5'h00;
            left <= 5'h00;
        end else begin
            idx <= next_idx;
            left <= next_left;
        end
    end
    // a sweep visits each idx once; pulses only while busy
    always_comb begin
        busy = (left != 5'h00);
        events.lk_valid = busy;
        events.lk_kind = cse_pkg::cse_req_t'(idx[1:0]);
        events.lk_state = 5'h01 << idx[4:2];
        events.lk_node = idx[2:0];
        events.lk_tid = ~idx;
        events.ev_valid = busy && !idx[4];
        events.ev_state = 4'h1 << idx[1:0];
        events.ev_node = idx[2:0];
        events.fq_miss_occ = busy ? idx + 5'h01 : 5'h00;
        events.misc = busy ? 4'h1 << idx[1:0] : 4'h0;
        events.misc_tid = ~idx;
    end
endmodule : cse_event_source

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic                 sys_clk;
    logic                 rst_n;
    logic                 cyc;
    logic                 we;
    logic [7:0]           adr;
    logic [31:0]          wdat;
    logic [31:0]          rdat;
    logic [31:0]          rd;
    logic                 ack;
    logic                 go;
    logic                 busy;
    int                   miscompares;
    int                   n_compared;
    cse_pkg::cse_events_t ev;
    cse_slice_event_select u_dut (.sys_clk, .rst_n, .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .events(ev));
    cse_event_source u_src (.sys_clk, .rst_n, .go, .busy, .events(ev));
    // 100 MHz
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [43:0] got, input logic [43:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got %h want %h", $time, got, exp);
        end
    endtask : check
    // one classic cycle; held until ack is sampled, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rd = rdat;
        cyc <= 1'b0;
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
    endtask : xfer
    task automatic rc(input logic [7:0] a, input logic [43:0] e);
        xfer(1'b0, a, 32'h0);
        check({12'h000, rd}, e);
    endtask : rc
    function automatic logic [31:0] ctl(input logic [7:0] e, u, th,
                                        input logic ed);
        return {th, 4'h4, 1'b0, ed, 2'b00, u, e};
    endfunction : ctl
    function automatic logic [31:0] flt(input logic [4:0] s,
                                        input logic [7:0] n);
        return {9'h000, s, n, 10'h000};
    endfunction : flt
    // expected count over one full 20-step sweep of the event source
    function automatic logic [43:0] want(input logic [7:0] e, u,
                                         input logic [4:0] s,
                                         input logic [7:0] n);
        logic [43:0] c;
        logic [4:0]  i;
        logic        hit;
        c = 44'h0;
        for (int j = 0; j < 20; j++) begin
            i = 5'(j);
            hit = 1'b0;
            if (e == cse_pkg::EV_LOOKUP) begin
                hit = u[0] && s[i[4:2]] && (!u[6] || n[i[2:0]]) &&
                      (u[3:1] == 3'b000 ||
                       (i[1:0] != 2'b11 && u[i[1:0] + 1]));
            end else if (e == cse_pkg::EV_EVICT) begin
                hit = !i[4] && (u[3:0] == 4'h0 ? u[6] : u[i[1:0]]) &&
                      (!u[6] || n[i[2:0]]);
            end else if (e == cse_pkg::EV_MISC) begin
                hit = u[i[1:0]];
            end
            c = c + 44'(hit);
        end
        return c;
    endfunction : want
    task automatic run_set(input logic [31:0] f, input logic [31:0] c[4],
                           input logic [43:0] e[4]);
        int n;
        xfer(1'b1, 8'h30, f);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, 8'h10 + 8'(4 * k), 32'h0);
            xfer(1'b1, 8'h20 + 8'(4 * k), 32'h0);
            xfer(1'b1, 8'(4 * k), c[k]);
        end
        @(posedge sys_clk);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (busy === 1'b1 && n < 40);
        // a sweep that never ends is a failure, not a silent pass
        if (n >= 40) begin
            miscompares++;
            conclude();
        end
        for (int k = 0; k < 4; k++) xfer(1'b1, 8'(4 * k), 32'h0);
        for (int k = 0; k < 4; k++) rc(8'h10 + 8'(4 * k), e[k]);
    endtask : run_set
    // counters 2 and 3 must stay still for pair-only events
    task automatic sel_case(input logic [7:0] e, u, input logic [4:0] s,
                            input logic [7:0] n);
        logic [31:0] c;
        logic [43:0] w;
        c = ctl(e, u, 8'h00, 1'b0);
        w = want(e, u, s, n);
        run_set(flt(s, n), '{c, c, c, c}, '{w, w, 44'h0, 44'h0});
    endtask : sel_case
    task automatic t_regs;
        for (int k = 0; k < 16; k++) rc(8'(4 * k), 44'h0);
        xfer(1'b1, 8'h10, 32'hFFFFFFFF);
        xfer(1'b1, 8'h20, 32'hFFFFFFFF);
        rc(8'h10, 44'hFFFFFFFF);
        rc(8'h20, 44'h00000FFF);
        xfer(1'b1, 8'h30, 32'hFFFFFFFF);
        rc(8'h30, 44'hFFFFFC1F);
        xfer(1'b1, 8'h34, 32'h00000005);
        rc(8'h34, 44'h0);
        rc(8'h11, 44'h0);
    endtask : t_regs
    // enables and disables are spaced alike, so each sees 12 clocks
    task automatic t_tick;
        for (int k = 0; k < 8; k++) xfer(1'b1, 8'h10 + 8'(4 * k), 32'h0);
        for (int k = 0; k < 4; k++)
            xfer(1'b1, 8'(4 * k), ctl(cse_pkg::EV_TICK, 0, 0, 0));
        for (int k = 0; k < 4; k++) xfer(1'b1, 8'(4 * k), 32'h0);
        for (int k = 0; k < 4; k++) rc(8'h10 + 8'(4 * k), 44'd12);
    endtask : t_tick
    task automatic t_occ;
        logic [31:0] q;
        logic [31:0] r;
        q = ctl(cse_pkg::EV_FQ_MISS, 8'h00, 8'h00, 1'b0);
        r = ctl(cse_pkg::EV_REFILT, 8'h00, 8'h01, 1'b0);
        run_set(32'h0, '{q, r, r | 32'h00040000, r & 32'h00FFFFFF},
                '{44'd210, 44'd20, 44'd1, 44'd210});
        run_set(32'h0, '{r, q, q, 32'h0},
                '{44'h0, 44'd210, 44'h0, 44'h0});
    endtask : t_occ
    task automatic t_lookup;
        logic [7:0] um [8] = '{8'h03, 8'h05, 8'h09, 8'h01,
                               8'h03, 8'h02, 8'h41, 8'h01};
        logic [4:0] st [8] = '{5'h1F, 5'h1F, 5'h1F, 5'h1F,
                               5'h00, 5'h1F, 5'h01, 5'h12};
        logic [31:0] c;
        for (int k = 0; k < 8; k++)
            sel_case(cse_pkg::EV_LOOKUP, um[k], st[k],
                     8'h05);
        // thread 0x1F matches only idx 0, once per sweep
        c = ctl(cse_pkg::EV_LOOKUP, 8'h01, 8'h00, 1'b0) | 32'h00080000;
        run_set(flt(5'h1F, 8'h00) | 32'h0000001F, '{c, c, c, c},
                '{44'd1, 44'd1, 44'h0, 44'h0});
    endtask : t_lookup
    task automatic t_evict;
        logic [7:0] um [7] = '{8'h01, 8'h02, 8'h04, 8'h08,
                               8'h40, 8'h41, 8'h0F};
        for (int k = 0; k < 7; k++)
            sel_case(cse_pkg::EV_EVICT, um[k], 5'h00, 8'h0A);
    endtask : t_evict
    task automatic t_misc;
        logic [7:0] um [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0B};
        for (int k = 0; k < 5; k++)
            sel_case(cse_pkg::EV_MISC, um[k], 5'h00,
                     8'h00);
    endtask : t_misc
    // reset for five clocks, then every scenario in turn
    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        go = 1'b0;
        miscompares = 0;
        n_compared = 0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_tick();
        t_occ();
        t_lookup();
        t_evict();
        t_misc();
        conclude();
    end
endmodule : tb_top
